// ===== pkg/pess_cfg.svh
// Purpose: offsets, field positions, reset values of the event source / shutdown block
// Assumes: wishbone byte addressing, one 8-bit register per aligned 32-bit word
// Notes: definitions only
`ifndef PESS_CFG_SVH
`define PESS_CFG_SVH
`define PESS_OFF_FALL_SRC 6'h00
`define PESS_OFF_PER_SRC 6'h04
`define PESS_OFF_SD_CTRL 6'h08
`define PESS_OFF_SD_SRC 6'h0c
`define PESS_OFF_SD_LVL 6'h10
`define PESS_OFF_TMR_LO 6'h14
`define PESS_OFF_TMR_HI 6'h18
`define PESS_OFF_DUTY_LO 6'h1c
`define PESS_OFF_DUTY_HI 6'h20
`define PESS_OFF_PER_LO 6'h24
`define PESS_OFF_PER_HI 6'h28
`define PESS_OFF_PWM_IN 6'h2c
`define PESS_OFF_EVENTS 6'h30
`define PESS_SRC_MASK 8'h9f
`define PESS_SD_SRC_MASK 8'h9e
`define PESS_SD_CTRL_MASK 8'he1
`define PESS_LVL_MASK 8'h3f
`define PESS_BIT_TB 0
`define PESS_BIT_PIN 7
`define PESS_BIT_STATUS 7
`define PESS_BIT_SDEN 6
`define PESS_BIT_ARS 5
`define PESS_BIT_OVR 0
`define PESS_RST_REG 8'h00
`define PESS_RST_WORD 16'h0000
`endif

// ===== pkg/pess_pkg.sv
// Purpose: types shared by the event source / shutdown block
// Assumes: nothing
// Notes: constants live in pess_cfg.svh
package pess_pkg;
   typedef enum logic [1:0] {
      PESS_BUS_IDLE,
      PESS_BUS_ACK
   } pess_bus_t;
endpackage

// ===== src/pess_sync.sv
// Purpose: two-flop synchroniser plus rising edge pulse for asynchronous inputs
// Assumes: one clock
// Notes: first flop feeds only the second
module pess_sync #(
   parameter int WIDTH = 5
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] level_o,
   output logic [WIDTH-1:0] rise_o
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
      logic [WIDTH-1:0] prev;
   } pess_sync_t;
   pess_sync_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.meta = async_i;
      s_d.sync = s_q.meta;
      s_d.prev = s_q.sync;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign level_o = s_q.sync;
   assign rise_o = s_q.sync & ~s_q.prev;
endmodule

// ===== src/pess_timebase.sv
// Purpose: 16-bit time base counter with byte writes and match detection
// Assumes: period reset has priority over software writes
// Notes: match pulses fire once per entry into equality
module pess_timebase #(
   parameter int WIDTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic reset_cnt_i,
   input wire logic wr_lo_i,
   input wire logic wr_hi_i,
   input wire logic [7:0] wdata_i,
   input wire logic [WIDTH-1:0] duty_i,
   input wire logic [WIDTH-1:0] period_i,
   output logic [WIDTH-1:0] count_o,
   output logic duty_match_o,
   output logic period_match_o
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic duty_eq;
      logic per_eq;
   } pess_tb_t;
   pess_tb_t s_q, s_d;
   logic duty_eq, per_eq;
   always_comb begin
      duty_eq = (s_q.cnt == duty_i);
      per_eq = (s_q.cnt == period_i);
      s_d = s_q;
      s_d.duty_eq = duty_eq;
      s_d.per_eq = per_eq;
      s_d.cnt = s_q.cnt + 1'b1;
      if (wr_lo_i) begin
         s_d.cnt[7:0] = wdata_i;
      end
      if (wr_hi_i) begin
         s_d.cnt[WIDTH-1:8] = wdata_i[WIDTH-9:0];
      end
      if (reset_cnt_i) begin
         s_d.cnt = '0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign count_o = s_q.cnt;
   // pulse only on entry, so a stalled count cannot retrigger
   assign duty_match_o = duty_eq & ~s_q.duty_eq;
   assign period_match_o = per_eq & ~s_q.per_eq;
endmodule

// ===== src/pess_top.sv
// Purpose: falling-edge / period event selection and auto-shutdown for one pwm channel
// Assumes: classic wishbone slave, 8-bit registers in low bits of 32-bit words
// Notes: pwm waveform itself arrives on pwm_i; outputs are registered
//
// The placing of the registers and register access over Wishbone were decided locally.
`include "pess_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module pess_top #(
   parameter int TB_WIDTH = 16,
   parameter int OUTS = 6
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [5:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic external_event_input_i,
   input wire logic [3:0] comparator_synced_i,
   input wire logic [OUTS-1:0] pwm_i,
   output logic [OUTS-1:0] pwm_o,
   output logic fall_event_o,
   output logic period_event_o,
   output logic shutdown_irq_flag_o
);
   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      pess_pkg::pess_bus_t bus;
      logic [31:0] rdata;
      logic [7:0] fall_src;
      logic [7:0] period_src;
      logic [7:0] sd_ctrl;
      logic [7:0] sd_src;
      logic [7:0] sd_lvl;
      logic [TB_WIDTH-1:0] duty;
      logic [TB_WIDTH-1:0] period;
      logic irq_flag;
      logic fall_ev;
      logic per_ev;
      logic [OUTS-1:0] outs;
   } pess_state_t;

   pess_state_t s_q, s_d;
   logic [4:0] src_level, src_rise;
   logic [TB_WIDTH-1:0] tb_count;
   logic duty_match, period_match;
   logic [7:0] fall_hits, per_hits, sd_hits;
   logic fall_now, per_now, sd_cond, sd_trigger, override_on, force_outs;
   logic access, wr, wr_lane0;
   logic [7:0] wbyte;

   ////////////////////////////////////////////////////////////////////////////
   // sync bit 0 carries cmp1; select bit 0, the timebase hit, is merged below
   pess_sync #(
      .WIDTH(5)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({external_event_input_i, comparator_synced_i}),
      .level_o(src_level),
      .rise_o(src_rise)
   );

   pess_timebase #(
      .WIDTH(TB_WIDTH)
   ) u_tb (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .reset_cnt_i(per_now),
      .wr_lo_i(wr_lane0 && adr_i == `PESS_OFF_TMR_LO),
      .wr_hi_i(wr_lane0 && adr_i == `PESS_OFF_TMR_HI),
      .wdata_i(wbyte),
      .duty_i(s_q.duty),
      .period_i(s_q.period),
      .count_o(tb_count),
      .duty_match_o(duty_match),
      .period_match_o(period_match)
   );

   ////////////////////////////////////////////////////////////////////////////
   // source vectors laid out as the select registers: pin bit 7, cmp4..1 bits 4..1
   assign fall_hits = {src_rise[4], 2'b00, src_rise[3:0], duty_match} & s_q.fall_src;
   assign per_hits = {src_rise[4], 2'b00, src_rise[3:0], period_match} & s_q.period_src;
   assign fall_now = |fall_hits;
   assign per_now = |per_hits;
   // shutdown condition is the level; a new shutdown needs a rising selected source
   assign sd_hits = {src_level[4], 2'b00, src_level[3:0], 1'b0} & s_q.sd_src;
   assign sd_cond = |sd_hits;
   assign sd_trigger = |({src_rise[4], 2'b00, src_rise[3:0], 1'b0} & s_q.sd_src)
      & s_q.sd_ctrl[`PESS_BIT_SDEN];
   assign override_on = s_q.sd_ctrl[`PESS_BIT_SDEN] & s_q.sd_ctrl[`PESS_BIT_OVR];
   assign access = cyc_i & stb_i & (s_q.bus == pess_pkg::PESS_BUS_IDLE);
   assign wr = access & we_i;
   assign wr_lane0 = wr & sel_i[0];
   assign wbyte = dat_i[7:0];

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d = s_q;
      s_d.fall_ev = fall_now;
      s_d.per_ev = per_now;
      // register writes, byte lane 0 only
      if (wr_lane0) begin
         unique case (adr_i)
            `PESS_OFF_FALL_SRC: s_d.fall_src = wbyte & `PESS_SRC_MASK;
            `PESS_OFF_PER_SRC: s_d.period_src = wbyte & `PESS_SRC_MASK;
            `PESS_OFF_SD_CTRL: s_d.sd_ctrl = wbyte & `PESS_SD_CTRL_MASK;
            `PESS_OFF_SD_SRC: s_d.sd_src = wbyte & `PESS_SD_SRC_MASK;
            `PESS_OFF_SD_LVL: s_d.sd_lvl = wbyte & `PESS_LVL_MASK;
            `PESS_OFF_DUTY_LO: s_d.duty[7:0] = wbyte;
            `PESS_OFF_DUTY_HI: s_d.duty[TB_WIDTH-1:8] = wbyte[TB_WIDTH-9:0];
            `PESS_OFF_PER_LO: s_d.period[7:0] = wbyte;
            `PESS_OFF_PER_HI: s_d.period[TB_WIDTH-1:8] = wbyte[TB_WIDTH-9:0];
            `PESS_OFF_EVENTS: begin
               // write one to bit 0 clears the interrupt flag
               if (wbyte[0]) begin
                  s_d.irq_flag = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      // auto restart: status drops once every selected source is low
      if (s_q.sd_ctrl[`PESS_BIT_ARS] && s_q.sd_ctrl[`PESS_BIT_STATUS] && !sd_cond && !sd_trigger) begin
         s_d.sd_ctrl[`PESS_BIT_STATUS] = 1'b0;
      end
      // hardware set wins over any software clear in the same cycle
      if (sd_trigger) begin
         s_d.sd_ctrl[`PESS_BIT_STATUS] = 1'b1;
         if (!s_q.sd_ctrl[`PESS_BIT_OVR]) begin
            s_d.irq_flag = 1'b1;
         end
      end
      // outputs follow status or override; status set by software acts the same
      force_outs = s_q.sd_ctrl[`PESS_BIT_STATUS] | override_on;
      for (int i = 0; i < OUTS; i++) begin
         s_d.outs[i] = force_outs ? s_q.sd_lvl[i] : pwm_i[i];
      end
      // bus handshake: one wait state, ack for one cycle
      s_d.rdata = 32'h0000_0000;
      unique case (s_q.bus)
         pess_pkg::PESS_BUS_IDLE: begin
            if (access) begin
               s_d.bus = pess_pkg::PESS_BUS_ACK;
               unique case (adr_i)
                  `PESS_OFF_FALL_SRC: s_d.rdata[7:0] = s_q.fall_src;
                  `PESS_OFF_PER_SRC: s_d.rdata[7:0] = s_q.period_src;
                  `PESS_OFF_SD_CTRL: s_d.rdata[7:0] = s_q.sd_ctrl;
                  `PESS_OFF_SD_SRC: s_d.rdata[7:0] = s_q.sd_src;
                  `PESS_OFF_SD_LVL: s_d.rdata[7:0] = s_q.sd_lvl;
                  `PESS_OFF_TMR_LO: s_d.rdata[7:0] = tb_count[7:0];
                  `PESS_OFF_TMR_HI: s_d.rdata[7:0] = tb_count[TB_WIDTH-1:8];
                  `PESS_OFF_DUTY_LO: s_d.rdata[7:0] = s_q.duty[7:0];
                  `PESS_OFF_DUTY_HI: s_d.rdata[7:0] = s_q.duty[TB_WIDTH-1:8];
                  `PESS_OFF_PER_LO: s_d.rdata[7:0] = s_q.period[7:0];
                  `PESS_OFF_PER_HI: s_d.rdata[7:0] = s_q.period[TB_WIDTH-1:8];
                  `PESS_OFF_PWM_IN: s_d.rdata[OUTS-1:0] = pwm_i;
                  `PESS_OFF_EVENTS: s_d.rdata[0] = s_q.irq_flag;
                  default: s_d.rdata = 32'h0000_0000;
               endcase
            end
         end
         pess_pkg::PESS_BUS_ACK: begin
            s_d.bus = pess_pkg::PESS_BUS_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.bus <= pess_pkg::PESS_BUS_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign dat_o = s_q.rdata;
   assign ack_o = (s_q.bus == pess_pkg::PESS_BUS_ACK);
   assign pwm_o = s_q.outs;
   assign fall_event_o = s_q.fall_ev;
   assign period_event_o = s_q.per_ev;
   assign shutdown_irq_flag_o = s_q.irq_flag;
endmodule

// ===== dv/pess_properties.sv
// Purpose: port-level assertions for pess_top
// Assumes: bound to pess_top, one clock domain
// Notes: register contents are seen only through bus reads
module pess_properties #(
   parameter int OUTS = 6
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [5:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic [OUTS-1:0] pwm_o,
   input wire logic fall_event_o,
   input wire logic period_event_o,
   input wire logic shutdown_irq_flag_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////////
   a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
   a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
   a_ack_idle: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("stray ack");
   a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("dat_o not zero");
   a_src_gaps: assert property (ack_o && (adr_i == 6'h00 || adr_i == 6'h04) |->
      (dat_o & 32'hffffff60) == 32'h0) else $error("source gap bits set");
   a_ctrl_gaps: assert property (ack_o && adr_i == 6'h08 |->
      (dat_o & 32'hffffff1e) == 32'h0) else $error("control gap bits set");
   a_unmapped_zero: assert property (ack_o && adr_i > 6'h33 |-> dat_o == 32'h0) else $error("unmapped data");
   // flag is sticky: only a bus write may clear it
   a_irq_sticky: assert property (shutdown_irq_flag_o && !(cyc_i && stb_i && we_i) |=>
      shutdown_irq_flag_o) else $error("flag dropped");
   a_reset_quiet: assert property ($fell(rst_i) |-> !fall_event_o && !period_event_o &&
      !shutdown_irq_flag_o && pwm_o == '0) else $error("outputs busy after reset");
endmodule
bind pess_top pess_properties #(.OUTS(OUTS)) u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .pwm_o(pwm_o),
   .fall_event_o(fall_event_o), .period_event_o(period_event_o), .shutdown_irq_flag_o(shutdown_irq_flag_o));

// ===== dv/pess_partner.sv
// Purpose: far side: fault pin, four comparators, pwm source
// Assumes: levels commanded by the bench
// Notes: pwm pattern alternates so a frozen output shows
module pess_partner (
   input wire logic clk_i,
   input wire logic [4:0] lvl_i,
   output logic pin_o = 1'b0,
   output logic [3:0] cmp_o = 4'h0,
   output logic [5:0] pwm_o = 6'h2a
);
   timeunit 1ns;
   timeprecision 1ns;
   // sources go true as clean level steps
   always @(posedge clk_i) begin
      pin_o <= lvl_i[4];
      cmp_o <= lvl_i[3:0];
      pwm_o <= ~pwm_o;
   end
endmodule

// ===== dv/tb_pess_top.sv
// Purpose: register-level tests of pess_top
// Assumes: wishbone reads give the low byte
// Notes: events watched over fixed windows
module tb_pess_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [5:0] adr_i = 6'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [4:0] lvl = 5'h00;
   logic [31:0] dat_o;
   logic ack_o, fall_event_o, period_event_o, shutdown_irq_flag_o, pin, f_seen, p_seen;
   logic [3:0] cmp;
   logic [5:0] pwm_i, pwm_o;
   logic [7:0] rdv, msk;
   int error_cnt = 0, total_checks = 0;
   always #20 clk_i = ~clk_i;
   pess_partner u_far (.clk_i(clk_i), .lvl_i(lvl), .pin_o(pin), .cmp_o(cmp), .pwm_o(pwm_i));
   pess_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .external_event_input_i(pin),
      .comparator_synced_i(cmp), .pwm_i(pwm_i), .pwm_o(pwm_o), .fall_event_o(fall_event_o),
      .period_event_o(period_event_o), .shutdown_irq_flag_o(shutdown_irq_flag_o));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   // one classic cycle; the idle edge at the end keeps stb low a cycle
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'h1;
      dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1) begin
         error_cnt++;
         $display("BAD %0t bus timeout", $time);
         end_of_test();
      end
      rdv = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(rdv, exp);
   endtask
   task automatic wat(input int n);
      f_seen = 1'b0;
      p_seen = 1'b0;
      repeat (n) begin
         @(posedge clk_i);
         f_seen |= (fall_event_o === 1'b1);
         p_seen |= (period_event_o === 1'b1);
      end
   endtask
   // raise one source, then drop it long enough for the synchroniser to settle
   task automatic pulse(input int b, input logic ef, input logic ep);
      lvl[b] <= 1'b1;
      wat(10);
      lvl[b] <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk(8'(f_seen), 8'(ef));
      chk(8'(p_seen), 8'(ep));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(6'h00, 8'h00);
      rd(6'h04, 8'h00);
      rd(6'h08, 8'h00);
      bus(1'b1, 6'h00, 8'hff);
      rd(6'h00, 8'h9f);
      bus(1'b1, 6'h04, 8'hff);
      rd(6'h04, 8'h9f);
      rd(6'h3c, 8'h00);
      for (int b = 0; b < 5; b++) begin
         msk = (b == 4) ? 8'h80 : 8'(2 << b);
         bus(1'b1, 6'h00, 8'h9e);
         bus(1'b1, 6'h04, msk);
         pulse(b, 1'b1, 1'b1);
         bus(1'b1, 6'h00, msk ^ 8'h9e);
         bus(1'b1, 6'h04, msk ^ 8'h9e);
         pulse(b, 1'b0, 1'b0);
      end
      bus(1'b1, 6'h1c, 8'h10);
      bus(1'b1, 6'h24, 8'h30);
      bus(1'b1, 6'h14, 8'h00);
      bus(1'b1, 6'h18, 8'h00);
      bus(1'b1, 6'h00, 8'h01);
      bus(1'b1, 6'h04, 8'h01);
      wat(120);
      chk(8'({f_seen, p_seen}), 8'h03);
      bus(1'b1, 6'h00, 8'h00);
      bus(1'b1, 6'h04, 8'h80);
      wat(120);
      chk(8'({f_seen, p_seen}), 8'h00);
      bus(1'b1, 6'h14, 8'h00);
      bus(1'b1, 6'h18, 8'h12);
      rd(6'h18, 8'h12);
      pulse(4, 1'b0, 1'b1);
      rd(6'h18, 8'h00);
      bus(1'b1, 6'h04, 8'h00);
      bus(1'b1, 6'h10, 8'h2d);
      bus(1'b1, 6'h0c, 8'h80);
      bus(1'b1, 6'h08, 8'h40);
      pulse(4, 1'b0, 1'b0);
      chk(8'(shutdown_irq_flag_o), 8'h01);
      chk(8'(pwm_o), 8'h2d);
      rd(6'h08, 8'hc0);
      bus(1'b1, 6'h08, 8'h40);
      chk(8'(pwm_o == 6'h2d), 8'h00);
      bus(1'b1, 6'h30, 8'h01);
      chk(8'(shutdown_irq_flag_o), 8'h00);
      bus(1'b1, 6'h0c, 8'h04);
      bus(1'b1, 6'h08, 8'h60);
      // status must be seen set while the source is high, so a missing set cannot pass
      lvl[1] <= 1'b1;
      wat(8);
      rd(6'h08, 8'he0);
      lvl[1] <= 1'b0;
      wat(8);
      chk(8'({f_seen, p_seen}), 8'h00);
      rd(6'h08, 8'h60);
      chk(8'(shutdown_irq_flag_o), 8'h01);
      bus(1'b1, 6'h30, 8'h01);
      bus(1'b1, 6'h08, 8'h41);
      chk(8'(pwm_o), 8'h2d);
      // a real trigger under override must still leave the flag clear
      pulse(1, 1'b0, 1'b0);
      chk(8'(shutdown_irq_flag_o), 8'h00);
      bus(1'b1, 6'h08, 8'h01);
      chk(8'(pwm_o == 6'h2d), 8'h00);
      bus(1'b1, 6'h08, 8'hc0);
      chk(8'(pwm_o), 8'h2d);
      bus(1'b1, 6'h08, 8'h00);
      pulse(1, 1'b0, 1'b0);
      chk(8'(shutdown_irq_flag_o), 8'h00);
      chk(8'(pwm_o == 6'h2d), 8'h00);
      end_of_test();
   end
endmodule
